//--- shared/status_word_pkg.sv
// Constants and types shared by the status word and exception entry block
// Operation
// - Compact r0-r7, stack pointer, link, counter share wide r0-r7, r13, r14, r15.
// - Each exception mode has its own stack pointer, link and saved word.
// - One current status word and five saved status words.
// - Flags N, Z, C, V update from operations and gate conditional execution.
// - Wide state: every instruction conditional; compact state: only branch.
// - Low eight bits change on entry; software writes I, F and mode only when privileged, and T only in a saved word.
// - Set interrupt disable bits block normal and fast interrupts.
// - State bit one means compact state; it drives an external indicator.
// - Mode codes: user, fast, normal, supervisor, abort, undefined, system.
// - Only the seven listed mode codes count as valid.
// - User/system unbanked; fast banks r8-r14; others bank r13, r14.
// - Compact state reaches high registers only through special variants.
// - Wide-state entry saves counter plus four or eight in target link.
// - Compact-state undefined and trap entry adjusts saved link so one return works.
// - Entry copies current status word to the target mode's saved word.
// - Entry forces mode, loads vector, may set interrupt disables.
// - Loading the vector clears the state bit, back to wide state.
// - Return loads counter from link minus offset and restores status word.
// - Return restores interrupt disables through the status word copy.
package status_word_pkg;
  localparam int XLEN = 32;
  localparam int NUM_LOW = 8;
  localparam int NUM_HI = 5;
  localparam int NUM_BANK = 6;
  localparam int NUM_SAVED = 5;

  localparam logic [4:0] MODE_USER  = 5'h10;
  localparam logic [4:0] MODE_FAST  = 5'h11;
  localparam logic [4:0] MODE_NORM  = 5'h12;
  localparam logic [4:0] MODE_SUPV  = 5'h13;
  localparam logic [4:0] MODE_ABORT = 5'h17;
  localparam logic [4:0] MODE_UNDEF = 5'h1b;
  localparam logic [4:0] MODE_SYS   = 5'h1f;

  // Bank slots: 0 shared user/system, 1..5 one per exception mode
  localparam logic [2:0] BANK_USER  = 3'h0;
  localparam logic [2:0] BANK_FAST  = 3'h1;
  localparam logic [2:0] BANK_NORM  = 3'h2;
  localparam logic [2:0] BANK_SUPV  = 3'h3;
  localparam logic [2:0] BANK_ABORT = 3'h4;
  localparam logic [2:0] BANK_UNDEF = 3'h5;

  localparam logic [3:0] IDX_HI_FIRST = 4'h8;
  localparam logic [3:0] IDX_HI_LAST  = 4'hc;
  localparam logic [3:0] IDX_STACK    = 4'hd;
  localparam logic [3:0] IDX_LINK     = 4'he;
  localparam logic [3:0] IDX_PC       = 4'hf;

  // Status word bit positions
  localparam int BIT_N = 31;
  localparam int BIT_Z = 30;
  localparam int BIT_C = 29;
  localparam int BIT_V = 28;
  localparam int BIT_I = 7;
  localparam int BIT_F = 6;
  localparam int BIT_T = 5;
  localparam int MODE_MSB = 4;

  localparam logic [XLEN-1:0] OFS_0 = 32'h0000_0000;
  localparam logic [XLEN-1:0] OFS_2 = 32'h0000_0002;
  localparam logic [XLEN-1:0] OFS_4 = 32'h0000_0004;
  localparam logic [XLEN-1:0] OFS_8 = 32'h0000_0008;

  localparam logic [XLEN-1:0] VEC_UNDEF = 32'h0000_0004;
  localparam logic [XLEN-1:0] VEC_TRAP  = 32'h0000_0008;
  localparam logic [XLEN-1:0] VEC_PABT  = 32'h0000_000c;
  localparam logic [XLEN-1:0] VEC_DABT  = 32'h0000_0010;
  localparam logic [XLEN-1:0] VEC_NORM  = 32'h0000_0018;
  localparam logic [XLEN-1:0] VEC_FAST  = 32'h0000_001c;
  localparam logic [XLEN-1:0] RESET_PC  = 32'h0000_0000;

  typedef enum logic [2:0] {
    EXC_UNDEF         = 3'h0,
    EXC_SOFTWARE_TRAP = 3'h1,
    EXC_PABT          = 3'h2,
    EXC_DABT          = 3'h3,
    EXC_NORM_INT      = 3'h4,
    EXC_FAST_INT      = 3'h5
  } exc_t;

  typedef enum logic [3:0] {
    CC_EQ = 4'h0, CC_NE = 4'h1, CC_CS = 4'h2, CC_CC = 4'h3,
    CC_MI = 4'h4, CC_PL = 4'h5, CC_VS = 4'h6, CC_VC = 4'h7,
    CC_HI = 4'h8, CC_LS = 4'h9, CC_GE = 4'ha, CC_LT = 4'hb,
    CC_GT = 4'hc, CC_LE = 4'hd, CC_AL = 4'he, CC_NV = 4'hf
  } cond_t;

  typedef struct packed {
    logic [3:0] nzcv;
    logic       irq_off;
    logic       fiq_off;
    logic       compact;
    logic [4:0] mode;
  } psr_t;

  localparam psr_t RESET_PSR = '{nzcv: 4'h0, irq_off: 1'b1, fiq_off: 1'b1,
                                 compact: 1'b0, mode: MODE_SUPV};

  typedef struct packed {
    logic       req;
    exc_t       kind;
  } exc_cmd_t;

  typedef struct packed {
    logic [7:0][XLEN-1:0]  low;
    logic [4:0][XLEN-1:0]  hi_user;
    logic [4:0][XLEN-1:0]  hi_fast;
    logic [5:0][XLEN-1:0]  stack;
    logic [5:0][XLEN-1:0]  link;
    logic [XLEN-1:0]       pc;
    psr_t                  current_status_word;
    psr_t [4:0]            saved_status_word;
    logic [XLEN-1:0]       rd_data;
    logic                  cond_pass;
    logic                  irq_go;
    logic                  fiq_go;
    logic                  mode_ok;
    logic                  priv;
  } state_t;
endpackage : status_word_pkg

//--- verilog/status_word_exception_entry.sv
// Status words, banked registers and exception entry and return
`timescale 1ns/100ps
`default_nettype none
module status_word_exception_entry (
  input  wire logic                              CORE_CLK,       // Core clock
  input  wire logic                              RSTN,           // Async reset, low
  input  wire logic [3:0]                        RD_IDX,         // Read register number
  input  wire logic [3:0]                        WR_IDX,         // Write register number
  input  wire logic                              WR_EN,          // Register write strobe
  input  wire logic [status_word_pkg::XLEN-1:0]  WR_DATA,        // Register write data
  input  wire logic                              HI_VARIANT,     // Special high access
  input  wire logic                              FLAG_WE,        // Update flags
  input  wire logic [3:0]                        FLAG_IN,        // New N Z C V
  input  wire logic [3:0]                        COND,           // Instruction condition
  input  wire logic                              IS_BRANCH,      // Instruction is branch
  input  wire logic                              PSR_WE,         // Status word write
  input  wire logic                              PSR_SAVED,      // Target saved word
  input  wire logic [status_word_pkg::XLEN-1:0]  PSR_DATA,       // Status write data
  input  wire logic                              PC_WE,          // Counter load
  input  wire logic [status_word_pkg::XLEN-1:0]  PC_IN,          // Counter value
  input  wire status_word_pkg::exc_cmd_t         EXC_ENTRY,      // Exception entry
  input  wire status_word_pkg::exc_cmd_t         EXC_RETURN,     // Exception return
  input  wire logic [status_word_pkg::XLEN-1:0]  VEC_BASE,       // Vector table base
  input  wire logic                              IRQ_REQ,        // Normal interrupt
  input  wire logic                              FIQ_REQ,        // Fast interrupt
  output logic [status_word_pkg::XLEN-1:0]       RD_DATA,        // Read data, one cycle
  output logic [status_word_pkg::XLEN-1:0]       PC_OUT,         // Program counter
  output logic [status_word_pkg::XLEN-1:0]       CURRENT_STATUS_WORD_OUT,       // Current word view
  output logic                                   STATE_INDICATOR, // Compact state
  output logic                                   COND_PASS,      // Instruction executes
  output logic                                   IRQ_GO,         // Unmasked normal int
  output logic                                   FIQ_GO,         // Unmasked fast int
  output logic                                   MODE_VALID,     // Mode code is legal
  output logic                                   PRIVILEGED      // Not user mode
);
  status_word_pkg::state_t s_q;
  status_word_pkg::state_t s_d;

  function automatic logic [2:0] bank_of(input logic [4:0] m);
    unique case (m)
      status_word_pkg::MODE_FAST:  bank_of = status_word_pkg::BANK_FAST;
      status_word_pkg::MODE_NORM:  bank_of = status_word_pkg::BANK_NORM;
      status_word_pkg::MODE_SUPV:  bank_of = status_word_pkg::BANK_SUPV;
      status_word_pkg::MODE_ABORT: bank_of = status_word_pkg::BANK_ABORT;
      status_word_pkg::MODE_UNDEF: bank_of = status_word_pkg::BANK_UNDEF;
      // Unlisted codes fall back to the shared user bank
      default:                     bank_of = status_word_pkg::BANK_USER;
    endcase
  endfunction : bank_of

  function automatic logic legal_mode(input logic [4:0] m);
    unique case (m)
      status_word_pkg::MODE_USER, status_word_pkg::MODE_FAST,
      status_word_pkg::MODE_NORM, status_word_pkg::MODE_SUPV,
      status_word_pkg::MODE_ABORT, status_word_pkg::MODE_UNDEF,
      status_word_pkg::MODE_SYS: legal_mode = 1'b1;
      default:                   legal_mode = 1'b0;
    endcase
  endfunction : legal_mode

  function automatic logic cond_ok(input logic [3:0] c, input logic [3:0] f);
    logic n;
    logic z;
    logic cy;
    logic v;

    {n, z, cy, v} = f;
    unique case (status_word_pkg::cond_t'(c))
      status_word_pkg::CC_EQ: cond_ok = z;
      status_word_pkg::CC_NE: cond_ok = !z;
      status_word_pkg::CC_CS: cond_ok = cy;
      status_word_pkg::CC_CC: cond_ok = !cy;
      status_word_pkg::CC_MI: cond_ok = n;
      status_word_pkg::CC_PL: cond_ok = !n;
      status_word_pkg::CC_VS: cond_ok = v;
      status_word_pkg::CC_VC: cond_ok = !v;
      status_word_pkg::CC_HI: cond_ok = cy && !z;
      status_word_pkg::CC_LS: cond_ok = !cy || z;
      status_word_pkg::CC_GE: cond_ok = n == v;
      status_word_pkg::CC_LT: cond_ok = n != v;
      status_word_pkg::CC_GT: cond_ok = !z && (n == v);
      status_word_pkg::CC_LE: cond_ok = z || (n != v);
      status_word_pkg::CC_AL: cond_ok = 1'b1;
      status_word_pkg::CC_NV: cond_ok = 1'b0;
    endcase
  endfunction : cond_ok

  function automatic logic [31:0] psr_word(input status_word_pkg::psr_t p);
    psr_word = '0;
    psr_word[status_word_pkg::BIT_N:status_word_pkg::BIT_V] = p.nzcv;
    psr_word[status_word_pkg::BIT_I] = p.irq_off;
    psr_word[status_word_pkg::BIT_F] = p.fiq_off;
    psr_word[status_word_pkg::BIT_T] = p.compact;
    psr_word[status_word_pkg::MODE_MSB:0] = p.mode;
  endfunction : psr_word

  // Read view of one register under the current mode's banking
  function automatic logic [31:0] read_reg(input status_word_pkg::state_t st,
                                           input logic [3:0] idx, input logic [2:0] bk);
    logic [2:0] hi;
    hi = 3'(idx - status_word_pkg::IDX_HI_FIRST);
    if (idx < status_word_pkg::IDX_HI_FIRST)
      read_reg = st.low[idx[2:0]];
    else if (idx <= status_word_pkg::IDX_HI_LAST)
      read_reg = (bk == status_word_pkg::BANK_FAST) ? st.hi_fast[hi] : st.hi_user[hi];
    else if (idx == status_word_pkg::IDX_STACK)
      read_reg = st.stack[bk];
    else if (idx == status_word_pkg::IDX_LINK)
      read_reg = st.link[bk];
    else
      read_reg = st.pc;
  endfunction : read_reg

  logic [2:0]                         bank;
  logic [2:0]                         tgt_bank;
  logic [4:0]                         tgt_mode;
  logic [31:0]                        vec_ofs;
  logic [31:0]                        link_ofs;
  logic [31:0]                        ret_ofs;
  logic [2:0]                         hi_w;
  logic                               hi_blocked_rd;
  logic                               hi_blocked_wr;
  status_word_pkg::psr_t              new_psr;

  always_comb
  begin
    s_d = s_q;
    bank = bank_of(s_q.current_status_word.mode);
    hi_w = 3'(WR_IDX - status_word_pkg::IDX_HI_FIRST);
    new_psr = s_q.current_status_word;
    tgt_mode = status_word_pkg::MODE_UNDEF;
    vec_ofs = status_word_pkg::VEC_UNDEF;
    link_ofs = status_word_pkg::OFS_4;
    ret_ofs = status_word_pkg::OFS_0;

    // High registers in compact state only through the special variants
    hi_blocked_rd = s_q.current_status_word.compact && !HI_VARIANT &&
                    RD_IDX >= status_word_pkg::IDX_HI_FIRST &&
                    RD_IDX <= status_word_pkg::IDX_HI_LAST;
    hi_blocked_wr = s_q.current_status_word.compact && !HI_VARIANT &&
                    WR_IDX >= status_word_pkg::IDX_HI_FIRST &&
                    WR_IDX <= status_word_pkg::IDX_HI_LAST;

    unique case (EXC_ENTRY.kind)
      status_word_pkg::EXC_UNDEF:
      begin
        tgt_mode = status_word_pkg::MODE_UNDEF;
        vec_ofs = status_word_pkg::VEC_UNDEF;
        link_ofs = s_q.current_status_word.compact ? status_word_pkg::OFS_2 : status_word_pkg::OFS_4;
      end
      status_word_pkg::EXC_SOFTWARE_TRAP:
      begin
        tgt_mode = status_word_pkg::MODE_SUPV;
        vec_ofs = status_word_pkg::VEC_TRAP;
        link_ofs = s_q.current_status_word.compact ? status_word_pkg::OFS_2 : status_word_pkg::OFS_4;
      end
      status_word_pkg::EXC_PABT:
      begin
        tgt_mode = status_word_pkg::MODE_ABORT;
        vec_ofs = status_word_pkg::VEC_PABT;
      end
      status_word_pkg::EXC_DABT:
      begin
        tgt_mode = status_word_pkg::MODE_ABORT;
        vec_ofs = status_word_pkg::VEC_DABT;
        link_ofs = status_word_pkg::OFS_8;
      end
      status_word_pkg::EXC_NORM_INT:
      begin
        tgt_mode = status_word_pkg::MODE_NORM;
        vec_ofs = status_word_pkg::VEC_NORM;
      end
      status_word_pkg::EXC_FAST_INT:
      begin
        tgt_mode = status_word_pkg::MODE_FAST;
        vec_ofs = status_word_pkg::VEC_FAST;
      end
      default:
      begin
        tgt_mode = status_word_pkg::MODE_UNDEF;
        vec_ofs = status_word_pkg::VEC_UNDEF;
      end
    endcase

    tgt_bank = bank_of(tgt_mode);

    unique case (EXC_RETURN.kind)
      status_word_pkg::EXC_PABT,
      status_word_pkg::EXC_NORM_INT,
      status_word_pkg::EXC_FAST_INT: ret_ofs = status_word_pkg::OFS_4;
      status_word_pkg::EXC_DABT:     ret_ofs = status_word_pkg::OFS_8;
      default:                       ret_ofs = status_word_pkg::OFS_0;
    endcase

    // Ordinary register write
    if (WR_EN && !hi_blocked_wr)
    begin
      if (WR_IDX < status_word_pkg::IDX_HI_FIRST)
        s_d.low[WR_IDX[2:0]] = WR_DATA;
      else if (WR_IDX <= status_word_pkg::IDX_HI_LAST)
      begin
        if (bank == status_word_pkg::BANK_FAST)
          s_d.hi_fast[hi_w] = WR_DATA;
        else
          s_d.hi_user[hi_w] = WR_DATA;
      end
      else if (WR_IDX == status_word_pkg::IDX_STACK)
        s_d.stack[bank] = WR_DATA;
      else if (WR_IDX == status_word_pkg::IDX_LINK)
        s_d.link[bank] = WR_DATA;
      else
        s_d.pc = WR_DATA;
    end

    // Counter load beats a write to r15 in the same cycle
    if (PC_WE)
      s_d.pc = PC_IN;

    if (FLAG_WE)
      new_psr.nzcv = FLAG_IN;

    // State bit is not taken from a current word write, so it is kept as stored
    if (PSR_WE && !PSR_SAVED)
    begin
      new_psr.nzcv = PSR_DATA[status_word_pkg::BIT_N:status_word_pkg::BIT_V];
      if (s_q.priv)
      begin
        new_psr.irq_off = PSR_DATA[status_word_pkg::BIT_I];
        new_psr.fiq_off = PSR_DATA[status_word_pkg::BIT_F];
        new_psr.mode = PSR_DATA[status_word_pkg::MODE_MSB:0];
      end
    end

    // No saved word in user or system mode, so such a write is dropped
    if (PSR_WE && PSR_SAVED && bank != status_word_pkg::BANK_USER)
    begin
      s_d.saved_status_word[3'(bank - 3'h1)] = '{nzcv: PSR_DATA[status_word_pkg::BIT_N:status_word_pkg::BIT_V],
                                 irq_off: PSR_DATA[status_word_pkg::BIT_I],
                                 fiq_off: PSR_DATA[status_word_pkg::BIT_F],
                                 compact: PSR_DATA[status_word_pkg::BIT_T],
                                 mode: PSR_DATA[status_word_pkg::MODE_MSB:0]};
    end

    s_d.current_status_word = new_psr;

    // Return takes precedence over ordinary updates; user/system have no saved word
    if (EXC_RETURN.req && bank != status_word_pkg::BANK_USER)
    begin
      s_d.pc = s_q.link[bank] - ret_ofs;
      s_d.current_status_word = s_q.saved_status_word[3'(bank - 3'h1)];
    end

    // Entry wins for counter, link, saved word, mode, I and T bits; flags keep this cycle's other updates
    if (EXC_ENTRY.req)
    begin
      s_d.link[tgt_bank] = s_q.pc + link_ofs;
      s_d.saved_status_word[3'(tgt_bank - 3'h1)] = s_q.current_status_word;
      s_d.current_status_word.mode = tgt_mode;
      s_d.current_status_word.irq_off = 1'b1;
      if (EXC_ENTRY.kind == status_word_pkg::EXC_FAST_INT)
        s_d.current_status_word.fiq_off = 1'b1;
      s_d.current_status_word.compact = 1'b0;
      s_d.pc = VEC_BASE + vec_ofs;
    end

    s_d.rd_data = hi_blocked_rd ? '0 : read_reg(s_q, RD_IDX, bank);
    s_d.cond_pass = (s_q.current_status_word.compact && !IS_BRANCH) ? 1'b1
                                                     : cond_ok(COND, s_q.current_status_word.nzcv);

    // Masks use the word of this edge, so a mask write acts at once
    s_d.irq_go = IRQ_REQ && !s_d.current_status_word.irq_off;
    s_d.fiq_go = FIQ_REQ && !s_d.current_status_word.fiq_off;
    s_d.mode_ok = legal_mode(s_d.current_status_word.mode);
    s_d.priv = s_d.current_status_word.mode != status_word_pkg::MODE_USER;
  end

  always_ff @(posedge CORE_CLK or negedge RSTN)
  begin
    if (!RSTN)
    begin
      // Supervisor with both interrupts off, as a cold start needs
      s_q <= '0;
      s_q.pc <= status_word_pkg::RESET_PC;
      s_q.current_status_word <= status_word_pkg::RESET_PSR;
      s_q.mode_ok <= 1'b1;
      s_q.priv <= 1'b1;
    end
    else
      s_q <= s_d;
  end

  // Outputs are plain views of registered state
  assign RD_DATA = s_q.rd_data;
  assign PC_OUT = s_q.pc;
  assign CURRENT_STATUS_WORD_OUT = psr_word(s_q.current_status_word);
  assign STATE_INDICATOR = s_q.current_status_word.compact;
  assign COND_PASS = s_q.cond_pass;
  assign IRQ_GO = s_q.irq_go;
  assign FIQ_GO = s_q.fiq_go;
  assign MODE_VALID = s_q.mode_ok;
  assign PRIVILEGED = s_q.priv;
endmodule : status_word_exception_entry
`default_nettype wire

//--- dv/status_word_exception_entry_assertions.sv
// Port-level checks for the status word and exception entry block
`timescale 1ns/100ps
`default_nettype none
module status_word_exception_entry_assertions (
  input wire logic                      CORE_CLK,        // Core clock
  input wire logic                      RSTN,            // Async reset, low
  input wire logic                      FLAG_WE,         // Flag update
  input wire logic [3:0]                FLAG_IN,         // New flags
  input wire logic                      IS_BRANCH,       // Branch instruction
  input wire logic                      PSR_WE,          // Status write
  input wire logic                      PSR_SAVED,       // Saved word target
  input wire status_word_pkg::exc_cmd_t EXC_ENTRY,       // Entry request
  input wire status_word_pkg::exc_cmd_t EXC_RETURN,      // Return request
  input wire logic [31:0]               VEC_BASE,        // Vector base
  input wire logic                      IRQ_REQ,         // Normal interrupt
  input wire logic                      FIQ_REQ,         // Fast interrupt
  input wire logic [31:0]               PC_OUT,          // Counter
  input wire logic [31:0]               CURRENT_STATUS_WORD_OUT,        // Current word
  input wire logic                      STATE_INDICATOR, // Compact state
  input wire logic                      COND_PASS,       // Executes
  input wire logic                      IRQ_GO,          // Normal taken
  input wire logic                      FIQ_GO,          // Fast taken
  input wire logic                      MODE_VALID,      // Legal mode
  input wire logic                      PRIVILEGED       // Not user
);
  localparam logic [31:0] VOFS [6] = '{32'h4, 32'h8, 32'hc, 32'h10, 32'h18, 32'h1c};
  localparam logic [4:0]  VMODE [6] = '{5'h1b, 5'h13, 5'h17, 5'h17, 5'h12, 5'h11};

  default clocking cb @(posedge CORE_CLK);
  endclocking
  default disable iff (!RSTN);

  property p_mode_decode;
    MODE_VALID == (CURRENT_STATUS_WORD_OUT[4:0] inside {5'h10, 5'h11, 5'h12, 5'h13, 5'h17, 5'h1b, 5'h1f})
      && PRIVILEGED == (CURRENT_STATUS_WORD_OUT[4:0] != 5'h10);
  endproperty
  a_mode_decode: assert property (p_mode_decode) else $error("mode decode wrong");
  property p_irq_mask;
    IRQ_GO == ($past(IRQ_REQ) && !CURRENT_STATUS_WORD_OUT[7]) && STATE_INDICATOR == CURRENT_STATUS_WORD_OUT[5];
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("normal interrupt gate wrong");
  property p_fiq_mask;
    FIQ_GO == ($past(FIQ_REQ) && !CURRENT_STATUS_WORD_OUT[6]);
  endproperty
  a_fiq_mask: assert property (p_fiq_mask) else $error("fast interrupt gate wrong");
  property p_entry_vec;
    EXC_ENTRY.req |=> PC_OUT == $past(VEC_BASE) + VOFS[$past(EXC_ENTRY.kind)];
  endproperty
  a_entry_vec: assert property (p_entry_vec) else $error("entry vector wrong");
  property p_entry_word;
    EXC_ENTRY.req |=> CURRENT_STATUS_WORD_OUT[4:0] == VMODE[$past(EXC_ENTRY.kind)] && CURRENT_STATUS_WORD_OUT[7]
      && !CURRENT_STATUS_WORD_OUT[5] && !STATE_INDICATOR;
  endproperty
  a_entry_word: assert property (p_entry_word) else $error("entry control bits wrong");
  property p_flags;
    FLAG_WE && !PSR_WE && !EXC_ENTRY.req && !EXC_RETURN.req |=> CURRENT_STATUS_WORD_OUT[31:28] == $past(FLAG_IN);
  endproperty
  a_flags: assert property (p_flags) else $error("flag update wrong");
  property p_user_ctl;
    CURRENT_STATUS_WORD_OUT[4:0] == 5'h10 && PSR_WE && !PSR_SAVED && !EXC_ENTRY.req |=> $stable(CURRENT_STATUS_WORD_OUT[7:0]);
  endproperty
  a_user_ctl: assert property (p_user_ctl) else $error("user changed control bits");
  property p_compact_cond;
    CURRENT_STATUS_WORD_OUT[5] && !IS_BRANCH |=> COND_PASS;
  endproperty
  a_compact_cond: assert property (p_compact_cond) else $error("compact non-branch held");
endmodule : status_word_exception_entry_assertions

bind status_word_exception_entry status_word_exception_entry_assertions
  status_word_exception_entry_assertions_inst (.CORE_CLK, .RSTN, .FLAG_WE, .FLAG_IN, .IS_BRANCH,
  .PSR_WE, .PSR_SAVED, .EXC_ENTRY, .EXC_RETURN, .VEC_BASE, .IRQ_REQ, .FIQ_REQ, .PC_OUT,
  .CURRENT_STATUS_WORD_OUT, .STATE_INDICATOR, .COND_PASS, .IRQ_GO, .FIQ_GO, .MODE_VALID, .PRIVILEGED);
`default_nettype wire

//--- dv/status_word_exception_entry_test.sv
// Self-checking bench for the status word and exception entry block
`timescale 1ns/100ps
`default_nettype none
module status_word_exception_entry_test;
  logic        CORE_CLK = 1'b0;
  logic        RSTN = 1'b0;
  logic [3:0]  RD_IDX = 4'h0, WR_IDX = 4'h0, FLAG_IN = 4'h0, COND = 4'h0;
  logic        WR_EN = 1'b0, HI_VARIANT = 1'b0, FLAG_WE = 1'b0, IS_BRANCH = 1'b0, PC_WE = 1'b0;
  logic        PSR_WE = 1'b0, PSR_SAVED = 1'b0, IRQ_REQ = 1'b0, FIQ_REQ = 1'b0;
  logic [31:0] WR_DATA = 32'h0, PSR_DATA = 32'h0, PC_IN = 32'h0, VEC_BASE = 32'h1000;
  logic [31:0] RD_DATA, PC_OUT, CURRENT_STATUS_WORD_OUT;
  logic        STATE_INDICATOR, COND_PASS, IRQ_GO, FIQ_GO, MODE_VALID, PRIVILEGED;
  status_word_pkg::exc_cmd_t EXC_ENTRY = '0, EXC_RETURN = '0;
  int          mismatches = 0, checks = 0, cycles = 0;

  status_word_exception_entry status_word_exception_entry_inst (.CORE_CLK, .RSTN, .RD_IDX,
    .WR_IDX, .WR_EN, .WR_DATA, .HI_VARIANT, .FLAG_WE, .FLAG_IN, .COND, .IS_BRANCH, .PSR_WE,
    .PSR_SAVED, .PSR_DATA, .PC_WE, .PC_IN, .EXC_ENTRY, .EXC_RETURN, .VEC_BASE, .IRQ_REQ,
    .FIQ_REQ, .RD_DATA, .PC_OUT, .CURRENT_STATUS_WORD_OUT, .STATE_INDICATOR, .COND_PASS, .IRQ_GO, .FIQ_GO,
    .MODE_VALID, .PRIVILEGED);

  always #50 CORE_CLK = ~CORE_CLK;

  // Whole run needs about 90 cycles
  always @(posedge CORE_CLK)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    if (mismatches == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : tally_and_finish

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Every strobe set on each step, so one not named in the step is low
  task automatic tick(input logic [11:0] s);
    {WR_EN, FLAG_WE, PSR_WE, PC_WE, EXC_ENTRY, EXC_RETURN} = s;
    @(negedge CORE_CLK);
  endtask : tick

  task automatic psr(input logic saved, input logic [31:0] d);
    {PSR_SAVED, PSR_DATA} = {saved, d};
    tick(12'h200);
  endtask : psr

  task automatic wr(input logic [3:0] idx, input logic [31:0] d);
    {WR_IDX, WR_DATA} = {idx, d};
    tick(12'h800);
  endtask : wr

  task automatic rd(input logic [3:0] idx, input logic [31:0] exp);
    RD_IDX = idx;
    tick(12'h000);
    check("RD_DATA", RD_DATA, exp);
  endtask : rd

  task automatic enter(input status_word_pkg::exc_t k, input logic [31:0] pc, input logic [7:0] c);
    tick({4'h0, 1'b1, k, 4'h0});
    check("PC_OUT", PC_OUT, pc);
    check("CURRENT_STATUS_WORD_OUT control", {24'h0, CURRENT_STATUS_WORD_OUT[7:0]}, {24'h0, c});
  endtask : enter

  task automatic ret(input status_word_pkg::exc_t k, input logic [31:0] pc, input logic [31:0] w);
    tick({8'h0, 1'b1, k});
    check("PC_OUT", PC_OUT, pc);
    check("CURRENT_STATUS_WORD_OUT", CURRENT_STATUS_WORD_OUT, w);
    check("STATE_INDICATOR", {31'h0, STATE_INDICATOR}, {31'h0, w[5]});
  endtask : ret

  task automatic t_reset();
    check("CURRENT_STATUS_WORD_OUT", CURRENT_STATUS_WORD_OUT, 32'h0000_00d3);
    check("valid/priv", {30'h0, MODE_VALID, PRIVILEGED}, 32'h3);
  endtask : t_reset

  task automatic t_bank();
    wr(4'hd, 32'h0000_a13d);
    wr(4'h8, 32'h0000_a008);
    psr(1'b0, 32'h0000_00df);
    rd(4'hd, 32'h0);
    wr(4'hd, 32'h0000_b13d);
    wr(4'h0, 32'h0000_0b00);
    psr(1'b0, 32'h0000_00d1);
    rd(4'h8, 32'h0);
    rd(4'h0, 32'h0000_0b00);
    wr(4'h8, 32'h0000_f008);
    psr(1'b0, 32'h0000_00d3);
    rd(4'hd, 32'h0000_a13d);
    rd(4'h8, 32'h0000_a008);
    psr(1'b0, 32'h0000_00df);
    rd(4'hd, 32'h0000_b13d);
  endtask : t_bank

  task automatic t_flags();
    logic [3:0]  fl [2] = '{4'h4, 4'h9};
    logic [15:0] pass [2] = '{16'h66a9, 16'h565a};
    for (int f = 0; f < 2; f++)
    begin
      FLAG_IN = fl[f];
      tick(12'h400);
      check("flags", {28'h0, CURRENT_STATUS_WORD_OUT[31:28]}, {28'h0, fl[f]});
      for (int c = 0; c < 16; c++)
      begin
        COND = c[3:0];
        tick(12'h000);
        check("COND_PASS", {31'h0, COND_PASS}, {31'h0, pass[f][c]});
      end
    end
  endtask : t_flags

  task automatic t_irq();
    {IRQ_REQ, FIQ_REQ} = 2'h3;
    psr(1'b0, 32'h0000_005f);
    check("go", {30'h0, IRQ_GO, FIQ_GO}, 32'h2);
    psr(1'b0, 32'h0000_009f);
    check("go", {30'h0, IRQ_GO, FIQ_GO}, 32'h1);
    {IRQ_REQ, FIQ_REQ} = 2'h0;
  endtask : t_irq

  task automatic t_modes();
    logic [4:0] code [8] = '{5'h11, 5'h12, 5'h13, 5'h17, 5'h1b, 5'h1f, 5'h15, 5'h10};
    for (int m = 0; m < 8; m++)
    begin
      psr(1'b0, {24'h0, 3'h6, code[m]});
      check("mode", {27'h0, CURRENT_STATUS_WORD_OUT[4:0]}, {27'h0, code[m]});
      check("valid/priv", {30'h0, MODE_VALID, PRIVILEGED}, {30'h0, m != 6, m < 7});
      if (m == 6)
      begin
        // Unlisted code stays privileged, so a status write could leave it; the bench uses reset
        RSTN = 1'b0;
        repeat (2) tick(12'h000);
        RSTN = 1'b1;
        check("CURRENT_STATUS_WORD_OUT", CURRENT_STATUS_WORD_OUT, 32'h0000_00d3);
      end
    end
    psr(1'b0, 32'h0000_001f);
    check("user control", {24'h0, CURRENT_STATUS_WORD_OUT[7:0]}, 32'h0000_00d0);
    enter(status_word_pkg::EXC_SOFTWARE_TRAP, 32'h0000_1008, 8'hd3);
    rd(4'he, 32'h0000_0004);
  endtask : t_modes

  task automatic t_exc();
    psr(1'b1, 32'h0000_003f);
    wr(4'he, 32'h0000_0200);
    ret(status_word_pkg::EXC_SOFTWARE_TRAP, 32'h0000_0200, 32'h0000_003f);
    COND = 4'hf;
    tick(12'h000);
    check("COND_PASS", {31'h0, COND_PASS}, 32'h1);
    IS_BRANCH = 1'b1;
    tick(12'h000);
    check("COND_PASS", {31'h0, COND_PASS}, 32'h0);
    IS_BRANCH = 1'b0;
    wr(4'h9, 32'h0000_0909);
    HI_VARIANT = 1'b1;
    rd(4'h9, 32'h0);
    wr(4'h9, 32'h0000_0909);
    rd(4'h9, 32'h0000_0909);
    HI_VARIANT = 1'b0;
    rd(4'h9, 32'h0);
    PC_IN = 32'h0000_0300;
    tick(12'h100);
    enter(status_word_pkg::EXC_NORM_INT, 32'h0000_1018, 8'h92);
    rd(4'he, 32'h0000_0304);
    ret(status_word_pkg::EXC_NORM_INT, 32'h0000_0300, 32'h0000_003f);
    enter(status_word_pkg::EXC_UNDEF, 32'h0000_1004, 8'h9b);
    rd(4'he, 32'h0000_0302);
    enter(status_word_pkg::EXC_DABT, 32'h0000_1010, 8'h97);
    rd(4'he, 32'h0000_100c);
    ret(status_word_pkg::EXC_DABT, 32'h0000_1004, 32'h0000_009b);
    enter(status_word_pkg::EXC_FAST_INT, 32'h0000_101c, 8'hd1);
    rd(4'he, 32'h0000_1008);
  endtask : t_exc

  initial
  begin
    repeat (5) @(negedge CORE_CLK);
    RSTN = 1'b1;
    t_reset();
    t_bank();
    t_flags();
    t_irq();
    t_modes();
    t_exc();
    tally_and_finish();
  end
endmodule : status_word_exception_entry_test
`default_nettype wire
